// ### itc_regs.svh
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH

// register byte offsets on the wishbone bus
`define ITC_OFS_DATA 8'h00
`define ITC_OFS_COUNT 8'h04
`define ITC_OFS_MODE 8'h08
`define ITC_OFS_INPUT 8'h0c
`define ITC_OFS_TRIG 8'h10
`define ITC_OFS_STATUS 8'h14
`define ITC_OFS_OUTCTL 8'h18
`define ITC_OFS_REWRITE 8'h1c
`define ITC_OFS_PRESC 8'h20

// channel_mode_config field positions
`define ITC_MC_CKS_LSB 14
`define ITC_MC_CCS 12
`define ITC_MC_MAS 11
`define ITC_MC_STS_LSB 8
`define ITC_MC_COS_LSB 6
`define ITC_MC_MD_LSB 1
`define ITC_MC_MD0 0
// implemented bits of channel_mode_config, reserved bits read zero
`define ITC_MC_MASK 16'hdfdf

// trigger register bits
`define ITC_TRIG_START 0
`define ITC_TRIG_STOP 1

// status register bits
`define ITC_ST_ENABLE 0
`define ITC_ST_OUTPUT 1
`define ITC_ST_ARMED 2

// output control register bits
`define ITC_OC_TOE 0
`define ITC_OC_TOM 1
`define ITC_OC_TOC 2
`define ITC_OC_TOL 3
`define ITC_OC_TDE 4
`define ITC_OC_TDL 5
`define ITC_OC_DIRECT 6

// reset values
`define ITC_RST_DATA 16'h0000
`define ITC_RST_MODE 16'h0000
`define ITC_RST_INPUT 2'h0
`define ITC_RST_OUTCTL 7'h01
`define ITC_RST_REWRITE 4'h0
`define ITC_RST_PRESC 16'h3210
`define ITC_RST_COUNT 16'h0000

// decode values for the interval function
`define ITC_MD_INTERVAL 4'h0
`define ITC_STS_SOFTWARE 3'h0
`define ITC_CCS_OPCLOCK 1'b0
`define ITC_COUNT_ZERO 16'h0000
`define ITC_COUNT_STEP 16'h0001

`endif

// ### itc_pkg.sv
package itc_pkg;

  // number of prescaler operation clocks
  localparam int ITC_N_CK = 4;

  // channel phase, gray along idle -> armed -> run
  typedef enum logic [1:0] {
    ITC_IDLE = 2'b00,
    ITC_ARMED = 2'b01,
    ITC_RUN = 2'b11
  } itc_phase_type;

  // classic wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } itc_wb_req_type;

  // bus slave state
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } itc_wb_type;

  // prescaler state
  typedef struct packed {
    logic [15:0] cnt;
  } itc_presc_type;

  // channel state
  typedef struct packed {
    itc_phase_type phase;
    logic [15:0] data_reg;
    logic [15:0] counter;
    logic [15:0] mode_cfg;
    logic [1:0] input_cfg;
    logic [6:0] out_ctl;
    logic [3:0] rewrite;
    logic [15:0] presc_sel;
    logic toggle;
    logic out;
    logic irq;
  } itc_chan_type;

endpackage : itc_pkg

// ### itc_prescaler.sv
`timescale 1ns/1ps
`include "itc_regs.svh"

module itc_prescaler
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // four 4-bit divide exponents, clock i = clk / 2**exp
  input wire logic [15:0] presc_sel,
  // one-cycle enable pulses, one per operation clock
  output logic [ITC_N_CK-1:0] ck_en
);

  itc_presc_type s; // registered state
  itc_presc_type next_s; // next state

  // free running divider, all taps share it so ticks stay aligned
  always_comb begin
    next_s = s;
    next_s.cnt = s.cnt + `ITC_COUNT_STEP;
  end

  // register the divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.cnt <= `ITC_COUNT_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // one tap per operation clock, exponent 0 ticks every cycle
  for (genvar i = 0; i < ITC_N_CK; i++) begin : g_tap
    logic [3:0] expo; // divide exponent of this tap
    logic [15:0] mask; // low counter bits that must be all ones
    assign expo = presc_sel[4*i +: 4];
    assign mask = (`ITC_COUNT_STEP << expo) - `ITC_COUNT_STEP;
    assign ck_en[i] = &(s.cnt | ~mask);
  end

endmodule : itc_prescaler

// ### itc_wb_slave.sv
`timescale 1ns/1ps
`include "itc_regs.svh"

module itc_wb_slave
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus request and read data from the register file
  input itc_wb_req_type req,
  input wire logic [31:0] rd_data,
  // write strobe, high in the cycle where ack is high
  output logic wr_en,
  // bus answer
  output logic ack_o,
  output logic [31:0] dat_o
);

  itc_wb_type s; // registered state
  itc_wb_type next_s; // next state

  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    if (req.cyc && req.stb && !s.ack) begin
      next_s.ack = 1'b1;
      // read data captured with the ack so it stands with it
      next_s.dat = req.we ? 32'h0000_0000 : rd_data;
    end
  end

  // register the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.ack <= 1'b0;
      s.dat <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  // writes land on the edge where the master sees ack
  assign wr_en = req.cyc && req.stb && req.we && s.ack;
  assign ack_o = s.ack;
  assign dat_o = s.dat;

endmodule : itc_wb_slave

// ### itc_channel.sv
// Functional notes
// - start trigger enables channel and loads counter
// - at zero: interrupt, toggle, reload, continue
// - data register change applies at next reload
// - stop trigger clears enable, freezes count, output
// - start while running restarts with reload
// - select bit 0: no interrupt at start
// - select bit 1: interrupt and toggle at start
// - interrupt period is tick times data plus one
// - output period is twice the interrupt period
// - two-bit field picks one of four clocks
// - count clock source 0 uses operation clock
// - start select 000: software start only
// - mode field 0000 decodes as interval timer
// - output enable 1 gives positive toggle output
// - output enable 0 drives software output level
// - start and stop bits self-clear, read zero
// - counter readable at any time
`timescale 1ns/1ps
`include "itc_regs.svh"

module itc_channel
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // channel pins
  output logic channel_interrupt,
  output logic channel_output
);

  itc_chan_type s; // registered channel state
  itc_chan_type next_s; // next channel state

  itc_wb_req_type req; // bundled bus request
  logic wr_en; // write strobe from the slave
  logic [31:0] rd_data; // read mux result
  logic [ITC_N_CK-1:0] ck_en; // prescaler ticks
  logic [1:0] cks; // selected operation clock
  logic tick; // count clock enable
  logic mode_ok; // channel set up for interval timing
  logic start_w; // start trigger written this cycle
  logic stop_w; // stop trigger written this cycle
  logic toe; // independent output enable

  // bundle the bus pins for the slave
  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we = wb_we_i;
  assign req.adr = wb_adr_i;
  assign req.sel = wb_sel_i;
  assign req.dat = wb_dat_i;

  // bus slave, answers one cycle after the request
  itc_wb_slave u_wb (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .ack_o(wb_ack_o),
    .dat_o(wb_dat_o)
  );

  // four operation clocks as enable pulses
  itc_prescaler u_presc (
    .clk(clk),
    .sys_rst(sys_rst),
    .presc_sel(s.presc_sel),
    .ck_en(ck_en)
  );

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] itc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : itc_merge

  // operation clock choice, code 00 first clock to 11 fourth
  assign cks = s.mode_cfg[`ITC_MC_CKS_LSB +: 2];
  // count clock is the operation clock itself
  assign tick = ck_en[cks];

  // only the interval setup lets a software start take hold;
  // other setups leave the channel parked rather than misbehave
  assign mode_ok =
    (s.mode_cfg[`ITC_MC_MD_LSB +: 4] == `ITC_MD_INTERVAL) &&
    (s.mode_cfg[`ITC_MC_STS_LSB +: 3] == `ITC_STS_SOFTWARE) &&
    (s.mode_cfg[`ITC_MC_CCS] == `ITC_CCS_OPCLOCK);

  // trigger bits decoded straight from the write, never stored
  assign start_w = wr_en && (req.adr == `ITC_OFS_TRIG) && req.sel[0]
    && req.dat[`ITC_TRIG_START];
  assign stop_w = wr_en && (req.adr == `ITC_OFS_TRIG) && req.sel[0]
    && req.dat[`ITC_TRIG_STOP];

  assign toe = s.out_ctl[`ITC_OC_TOE];

  // register read mux, unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (req.adr)
      // reload value
      `ITC_OFS_DATA: begin
        rd_data[15:0] = s.data_reg;
      end
      // live count, safe to read while running
      `ITC_OFS_COUNT: begin
        rd_data[15:0] = s.counter;
      end
      // mode word, reserved bits masked
      `ITC_OFS_MODE: begin
        rd_data[15:0] = s.mode_cfg & `ITC_MC_MASK;
      end
      // input edge select
      `ITC_OFS_INPUT: begin
        rd_data[1:0] = s.input_cfg;
      end
      // trigger bits always read back zero
      `ITC_OFS_TRIG: begin
        rd_data = 32'h0000_0000;
      end
      // channel status
      `ITC_OFS_STATUS: begin
        rd_data[`ITC_ST_ENABLE] = (s.phase != ITC_IDLE);
        rd_data[`ITC_ST_OUTPUT] = s.out;
        rd_data[`ITC_ST_ARMED] = (s.phase == ITC_ARMED);
      end
      // output control bits
      `ITC_OFS_OUTCTL: begin
        rd_data[6:0] = s.out_ctl;
      end
      // simultaneous rewrite bits, stored only
      `ITC_OFS_REWRITE: begin
        rd_data[3:0] = s.rewrite;
      end
      // prescaler exponents
      `ITC_OFS_PRESC: begin
        rd_data[15:0] = s.presc_sel;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // channel next state: bus writes, triggers, counting, output
  always_comb begin
    logic [31:0] wv; // merged write value
    logic fire; // interrupt event this cycle
    wv = 32'h0000_0000;
    fire = 1'b0;
    next_s = s;
    next_s.irq = 1'b0;

    // plain register writes
    if (wr_en) begin
      case (req.adr)
        // data register takes writes at any moment
        `ITC_OFS_DATA: begin
          wv = itc_merge({16'h0000, s.data_reg}, req.dat, req.sel);
          next_s.data_reg = wv[15:0];
        end
        // mode word
        `ITC_OFS_MODE: begin
          wv = itc_merge({16'h0000, s.mode_cfg}, req.dat, req.sel);
          next_s.mode_cfg = wv[15:0] & `ITC_MC_MASK;
        end
        // input edge select, unused in this function
        `ITC_OFS_INPUT: begin
          wv = itc_merge({30'h0000_0000, s.input_cfg}, req.dat, req.sel);
          next_s.input_cfg = wv[1:0];
        end
        // output control
        `ITC_OFS_OUTCTL: begin
          wv = itc_merge({25'h000_0000, s.out_ctl}, req.dat, req.sel);
          next_s.out_ctl = wv[6:0];
        end
        // rewrite bits have no effect here
        `ITC_OFS_REWRITE: begin
          wv = itc_merge({28'h000_0000, s.rewrite}, req.dat, req.sel);
          next_s.rewrite = wv[3:0];
        end
        // prescaler exponents
        `ITC_OFS_PRESC: begin
          wv = itc_merge({16'h0000, s.presc_sel}, req.dat, req.sel);
          next_s.presc_sel = wv[15:0];
        end
        // read-only, trigger and unmapped: nothing stored
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end

    // triggers first, they take the place of a count step
    if (stop_w) begin
      // stop wins over a start in the same write
      next_s.phase = ITC_IDLE;
    end else if (start_w && mode_ok) begin
      // arm, also while running: a forced restart
      next_s.phase = ITC_ARMED;
    end else begin
      case (s.phase)
        // stopped: counter and output hold
        ITC_IDLE: begin
          next_s.counter = s.counter;
        end
        // load waits for the start of the next count clock
        ITC_ARMED: begin
          if (tick) begin
            next_s.counter = s.data_reg;
            next_s.phase = ITC_RUN;
            fire = s.mode_cfg[`ITC_MC_MD0];
          end
        end
        // count down, reload at zero
        ITC_RUN: begin
          if (tick) begin
            if (s.counter == `ITC_COUNT_ZERO) begin
              // reload picks up the latest data register value
              next_s.counter = s.data_reg;
              fire = 1'b1;
            end else begin
              next_s.counter = s.counter - `ITC_COUNT_STEP;
            end
          end
        end
        default: begin
          next_s.phase = ITC_IDLE;
        end
      endcase
    end

    // interrupt pulse on each event, toggle too when toe is set
    next_s.irq = fire;
    if (fire && toe) begin
      // one toggle per interrupt halves the output rate
      next_s.toggle = ~s.toggle;
    end

    // output source: toggle flop or software level;
    // level invert is ignored in toggle mode, positive logic
    if (next_s.out_ctl[`ITC_OC_TOE]) begin
      next_s.out = next_s.toggle;
    end else begin
      next_s.out = next_s.out_ctl[`ITC_OC_DIRECT];
    end
  end

  // register the channel state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.phase <= ITC_IDLE;
      s.data_reg <= `ITC_RST_DATA;
      s.counter <= `ITC_RST_COUNT;
      s.mode_cfg <= `ITC_RST_MODE;
      s.input_cfg <= `ITC_RST_INPUT;
      s.out_ctl <= `ITC_RST_OUTCTL;
      s.rewrite <= `ITC_RST_REWRITE;
      s.presc_sel <= `ITC_RST_PRESC;
      s.toggle <= 1'b0;
      s.out <= 1'b0;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // pins straight from flops
  assign channel_interrupt = s.irq;
  assign channel_output = s.out;

endmodule : itc_channel

// ### itc_channel_checker.sv
`timescale 1ns/1ps
`include "itc_regs.svh"

module itc_channel_checker
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // channel pins
  input wire logic channel_interrupt,
  input wire logic channel_output
);
  logic wr; // write lands at the ack edge
  logic toe_q; // shadow of the toggle output enable
  logic run_q; // shadow of started or stopped, by software view
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  // shadow state; a refused start only leaves run_q high, which relaxes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      toe_q <= 1'b1;
      run_q <= 1'b0;
    end else if (wr && wb_adr_i == `ITC_OFS_OUTCTL) begin
      toe_q <= wb_dat_i[`ITC_OC_TOE];
    end else if (wr && wb_adr_i == `ITC_OFS_TRIG) begin
      if (wb_dat_i[`ITC_TRIG_STOP]) run_q <= 1'b0; // stop wins
      else if (wb_dat_i[`ITC_TRIG_START]) run_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // a fresh request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // toggle output mode settled for three cycles
  sequence s_toggle;
    toe_q && $past(toe_q) && $past(toe_q, 2);
  endsequence
  // channel stopped for two cycles
  sequence s_quiet;
    !run_q && !$past(run_q);
  endsequence

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_wr_data_zero: assert property (wb_ack_o && wb_we_i |->
    wb_dat_o == 32'h0000_0000) else $error("read data on a write");
  a_trig_reads_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `ITC_OFS_TRIG |->
    wb_dat_o == 32'h0000_0000)
    else $error("trigger bits read back set");
  a_irq_toggles: assert property (
    s_toggle ##0 channel_interrupt |->
    channel_output != $past(channel_output))
    else $error("interrupt without output toggle");
  a_out_cause: assert property (
    s_toggle ##0 $changed(channel_output) |-> channel_interrupt)
    else $error("output toggled without interrupt");
  a_stop_quiet: assert property (s_quiet |-> !channel_interrupt)
    else $error("interrupt while stopped");
  a_stop_hold: assert property (
    s_quiet ##0 s_toggle |-> $stable(channel_output))
    else $error("output moved while stopped");
endmodule : itc_channel_checker

bind itc_channel itc_channel_checker chk (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .channel_interrupt(channel_interrupt), .channel_output(channel_output));

// ### itc_channel_test.sv
`timescale 1ns/1ps

module itc_channel_test
  import itc_pkg::*;
;
  logic clk, sys_rst, cyc, stb, we, ack, irq, out;
  logic [7:0] adr;
  logic [31:0] dat_i, dat_o, rq, c1;
  int fail_count, samples_checked, t0;
  int cycles = 0; // free-running cycle count, only the always block drives it
  logic o1;

  itc_channel dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .channel_interrupt(irq), .channel_output(out));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cycle count for gaps and the hang guard; the run needs under 1000
  always @(posedge clk) begin
    cycles <= cycles + 1;
  end

  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    // no local limit: only the bench's cycle ceiling ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    check("ack", 1, ack);
    rq = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    check(nm, e, rq);
  endtask : rdc

  // bounded wait for an interrupt pulse
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 300);
    check("irq", 1, irq);
  endtask : wait_irq

  task automatic t_reset();
    rdc(8'h00, 32'h0000_0000, "data");
    rdc(8'h04, 32'h0000_0000, "count");
    rdc(8'h08, 32'h0000_0000, "mode");
    rdc(8'h18, 32'h0000_0001, "outctl");
    rdc(8'h20, 32'h0000_3210, "presc");
    rdc(8'h14, 32'h0000_0000, "status");
    wr(8'h24, 32'hffff_ffff);
    rdc(8'h24, 32'h0000_0000, "unmapped");
    wr(8'h08, 32'h0000_ffff);
    rdc(8'h08, 32'h0000_dfdf, "mode mask");
    wr(8'h08, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_period();
    wr(8'h0c, 32'h0000_0000);
    wr(8'h1c, 32'h0000_0000);
    wr(8'h18, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0002);
    wr(8'h10, 32'h0000_0001);
    // status bit1 follows the output, so only the enable bit is judged
    xfer(1'b0, 8'h14, 32'h0000_0000);
    check("enable", 1, rq[0]);
    rdc(8'h10, 32'h0000_0000, "trig");
    wait_irq();
    t0 = cycles;
    o1 = out;
    wait_irq();
    check("irq gap", 3, cycles - t0);
    check("out toggle", {31'h0, ~o1}, out);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    check("count range", 1, rq <= 2);
    $display("test period done");
  endtask : t_period

  task automatic t_select();
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, {16'h0000, k[1:0], 14'h0001});
      wr(8'h00, 32'h0000_0001);
      wr(8'h10, 32'h0000_0001);
      wait_irq();
      t0 = cycles;
      wait_irq();
      check("clock sel gap", 2 << k, cycles - t0);
    end
    $display("test select done");
  endtask : t_select

  task automatic t_rewrite();
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0009);
    wr(8'h10, 32'h0000_0001);
    wait_irq();
    t0 = cycles;
    wr(8'h00, 32'h0000_0003);
    // load of 9 one cycle before t0, four steps before the read is taken
    rdc(8'h04, 32'h0000_0005, "count step");
    wait_irq();
    check("old gap", 10, cycles - t0);
    t0 = cycles;
    wait_irq();
    check("new gap", 4, cycles - t0);
    $display("test rewrite done");
  endtask : t_rewrite

  task automatic t_stop();
    wr(8'h08, 32'h0000_c001);
    wr(8'h00, 32'h0000_0007);
    wr(8'h10, 32'h0000_0001);
    wait_irq();
    repeat (20) @(posedge clk);
    wr(8'h10, 32'h0000_0002);
    o1 = out;
    xfer(1'b0, 8'h04, 32'h0000_0000);
    c1 = rq;
    repeat (30) @(posedge clk);
    rdc(8'h04, c1, "frozen count");
    check("frozen out", o1, out);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    check("stopped", 0, rq[0]);
    wr(8'h10, 32'h0000_0001);
    wait_irq();
    repeat (20) @(posedge clk);
    wr(8'h10, 32'h0000_0001);
    t0 = cycles;
    wait_irq();
    check("restart irq", 1, cycles - t0 <= 10);
    wr(8'h08, 32'h0000_c000);
    wr(8'h10, 32'h0000_0001);
    t0 = cycles;
    wait_irq();
    check("no start irq", 1, cycles - t0 > 10);
    $display("test stop done");
  endtask : t_stop

  task automatic t_direct();
    wr(8'h18, 32'h0000_0040);
    rdc(8'h18, 32'h0000_0040, "outctl");
    wait_irq();
    repeat (2) @(posedge clk);
    check("direct high", 1, out);
    wr(8'h18, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check("direct low", 0, out);
    wr(8'h18, 32'h0000_0001);
    wr(8'h10, 32'h0000_0002);
    wr(8'h08, 32'h0000_0002);
    wr(8'h10, 32'h0000_0001);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    check("other mode", 0, rq[0]);
    $display("test direct done");
  endtask : t_direct

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    fail_count = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_i = 32'h0000_0000;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // tests race the cycle ceiling; either way one verdict follows
    fork
      begin
        t_reset();
        t_period();
        t_select();
        t_rewrite();
        t_stop();
        t_direct();
      end
      begin
        wait (cycles == 3000);
        fail_count++;
        $display("timeout at cycle %0d", cycles);
      end
    join_any
    close_out();
  end
endmodule : itc_channel_test
